// file: core/sac_regs.svh
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

`define SAC_ADDR_W        8
`define SAC_ADDR_LSB      2
`define SAC_ADDR_SCR      8'h3C
`define SAC_ADDR_RESULT   8'h40
`define SAC_ADDR_CLKDIV   8'h44
`define SAC_ADDR_IRQ_STAT 8'h48
`define SAC_ADDR_IRQ_MASK 8'h4C

`define SAC_SCR_DONE      7
`define SAC_SCR_IRQ_EN    6
`define SAC_SCR_CONT      5
`define SAC_CHAN_W        5
`define SAC_CHAN_OFF      5'h1F

`define SAC_DIV_HI       7
`define SAC_DIV_LO       5
`define SAC_DIV_W        3
`define SAC_DIV_PAD      5'h00
`define SAC_DIVCNT_W     4

`define SAC_IRQ_W        2
`define SAC_IRQ_DONE     0
`define SAC_IRQ_ABORT    1
`define SAC_MASK_RST     2'h3

`define SAC_NUM_CH       4
`define SAC_AIN_W        10
`define SAC_RES_W        8
`define SAC_CODE_MAX     8'hFF
`define SAC_CODE_MIN     8'h00
`define SAC_SAR_MSB      8'h80
`define SAC_CONV_TICKS   16
`define SAC_CNT_W        5
`define SAC_BUS_W        32

`endif

// file: core/sac_pkg.sv
`include "sac_regs.svh"

package sac_pkg;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_ARM  = 2'b01,
		SEQ_CONV = 2'b11
	} sac_seq_e;

	typedef struct packed {
		logic                  busy;
		logic                  done;
		logic [`SAC_CNT_W-1:0] cnt;
		logic [`SAC_RES_W-1:0] hold;
		logic [`SAC_RES_W-1:0] code;
		logic [`SAC_RES_W-1:0] bitm;
	} sac_eng_s;

	typedef struct packed {
		logic                                   ack;
		logic [`SAC_RES_W-1:0]                  rdata;
		logic [`SAC_CHAN_W-1:0]                 channel_select_field;
		logic                                   continuous_mode_bit;
		logic                                   conv_irq_enable;
		logic                                   conversion_done_flag;
		logic [`SAC_RES_W-1:0]                  result;
		logic [`SAC_DIV_W-1:0]                  prescale;
		logic [`SAC_DIVCNT_W-1:0]               div_cnt;
		logic                                   tick;
		sac_seq_e                               seq;
		logic [`SAC_IRQ_W-1:0]                  irq_stat;
		logic [`SAC_IRQ_W-1:0]                  irq_mask;
		logic [`SAC_NUM_CH-1:0][`SAC_AIN_W-1:0] ain_meta;
		logic [`SAC_NUM_CH-1:0][`SAC_AIN_W-1:0] ain_sync;
		logic [`SAC_NUM_CH-1:0][`SAC_AIN_W-1:0] ain_prev;
		logic [`SAC_NUM_CH-1:0][`SAC_AIN_W-1:0] ain_hold;
		logic [`SAC_NUM_CH-1:0]                 pin_meta;
		logic [`SAC_NUM_CH-1:0]                 pin_sync;
	} sac_ctl_s;

endpackage

// file: core/sac_sar_engine.sv
`include "sac_regs.svh"

module sac_sar_engine #(
	parameter int CONV_TICKS = `SAC_CONV_TICKS
) (
	input  wire logic                  clk_i,
	input  wire logic                  resetn_i,
	input  wire logic                  tick_i,
	input  wire logic                  start_i,
	input  wire logic                  abort_i,
	input  wire logic [`SAC_RES_W-1:0] sample_i,
	output logic                       busy_o,
	output logic                       done_o,
	output logic [`SAC_RES_W-1:0]      result_o
);

	localparam logic [`SAC_CNT_W-1:0] CNT_LAST = `SAC_CNT_W'(CONV_TICKS - 1);

	if (CONV_TICKS < 9 || CONV_TICKS > 31) begin : g_chk
		$error("sac_sar_engine: CONV_TICKS must lie in 9..31");
	end

	sac_pkg::sac_eng_s s;
	sac_pkg::sac_eng_s n;

	always_comb begin
		n = s;
		n.done = 1'b0;
		if (abort_i) begin
			n.busy = 1'b0;
		end else if (tick_i) begin
			if (start_i) begin
				// input captured once so a moving source cannot skew the bits
				n.busy = 1'b1;
				n.cnt  = '0;
				n.hold = sample_i;
				n.code = `SAC_CODE_MIN;
				n.bitm = `SAC_SAR_MSB;
			end else if (s.busy) begin
				if (|s.bitm) begin
					if ((s.code | s.bitm) <= s.hold) begin
						n.code = s.code | s.bitm;
					end
					n.bitm = s.bitm >> 1;
				end
				n.cnt = s.cnt + `SAC_CNT_W'(1);
				if (s.cnt == CNT_LAST) begin
					n.busy = 1'b0;
					n.done = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign busy_o   = s.busy;
	assign done_o   = s.done;
	assign result_o = s.code;

endmodule

// file: core/sac_adc_ctrl.sv
// Our own choice: the Wishbone slave port.
`include "sac_regs.svh"

module sac_adc_ctrl #(
	parameter int CONV_TICKS = `SAC_CONV_TICKS
) (
	input  wire logic                                   clk_i,
	input  wire logic                                   resetn_i,
	input  wire logic                                   wb_cyc_i,
	input  wire logic                                   wb_stb_i,
	input  wire logic                                   wb_we_i,
	input  wire logic [`SAC_ADDR_W-1:0]                 wb_adr_i,
	input  wire logic [3:0]                             wb_sel_i,
	input  wire logic [`SAC_BUS_W-1:0]                  wb_dat_i,
	output logic [`SAC_BUS_W-1:0]                       wb_dat_o,
	output logic                                        wb_ack_o,
	input  wire logic [`SAC_NUM_CH-1:0][`SAC_AIN_W-1:0] ain_i,
	input  wire logic [`SAC_NUM_CH-1:0]                 pin_in_i,
	output logic [`SAC_NUM_CH-1:0]                      pin_out_o,
	output logic [`SAC_NUM_CH-1:0]                      pin_oe_o,
	input  wire logic [`SAC_NUM_CH-1:0]                 port_latch_i,
	input  wire logic [`SAC_NUM_CH-1:0]                 port_ddr_i,
	output logic [`SAC_NUM_CH-1:0]                      port_read_o,
	input  wire logic                                   wait_mode_i,
	output logic                                        power_down_o,
	output logic                                        irq_o,
	output logic                                        wake_o
);

	if (CONV_TICKS < 9 || CONV_TICKS > 31) begin : g_chk
		$error("sac_adc_ctrl: CONV_TICKS must lie in 9..31");
	end

	// divide ratio minus one for the prescale code
	function automatic logic [`SAC_DIVCNT_W-1:0] ratio_m1(input logic [`SAC_DIV_W-1:0] code);
		logic [`SAC_DIVCNT_W-1:0] r;
		r = 4'h0;
		if (code[`SAC_DIV_W-1]) begin
			r = 4'hF;
		end else begin
			unique case (code[1:0])
				2'h0: r = 4'h0;
				2'h1: r = 4'h1;
				2'h2: r = 4'h3;
				2'h3: r = 4'h7;
			endcase
		end
		return r;
	endfunction

	// clamps a signed input level onto the code range
	function automatic logic [`SAC_RES_W-1:0] saturate(input logic [`SAC_AIN_W-1:0] v);
		logic [`SAC_RES_W-1:0] c;
		c = v[`SAC_RES_W-1:0];
		if (v[`SAC_AIN_W-1]) begin
			c = `SAC_CODE_MIN;
		end else if (|v[`SAC_AIN_W-2:`SAC_RES_W]) begin
			c = `SAC_CODE_MAX;
		end
		return c;
	endfunction

	function automatic logic hit(input logic [`SAC_ADDR_W-1:0] addr,
	                             input logic [`SAC_ADDR_W-1:0] base);
		return addr[`SAC_ADDR_W-1:`SAC_ADDR_LSB] == base[`SAC_ADDR_W-1:`SAC_ADDR_LSB];
	endfunction

	sac_pkg::sac_ctl_s      s;
	sac_pkg::sac_ctl_s      n;
	logic                   req;
	logic                   wr;
	logic                   rd;
	logic                   wr_scr;
	logic                   start;
	logic                   off;
	logic                   eng_done;
	logic [`SAC_RES_W-1:0]  eng_code;
	logic [`SAC_RES_W-1:0]  sample;
	logic [`SAC_NUM_CH-1:0] in_use;

	assign req    = wb_cyc_i & wb_stb_i & ~s.ack;
	assign wr     = req & wb_we_i & wb_sel_i[0];
	assign rd     = req & ~wb_we_i;
	assign wr_scr = wr & hit(wb_adr_i, `SAC_ADDR_SCR);
	assign off    = s.channel_select_field == `SAC_CHAN_OFF;
	// first converter clock after the write; a write in the tick cycle waits one more
	assign start  = (s.seq == sac_pkg::SEQ_ARM) & s.tick & ~wr_scr;

	always_comb begin
		sample = `SAC_CODE_MIN;
		if (s.channel_select_field < `SAC_CHAN_W'(`SAC_NUM_CH)) begin
			sample = saturate(s.ain_hold[s.channel_select_field[1:0]]);
		end
	end

	sac_sar_engine #(
		.CONV_TICKS (CONV_TICKS)
	) u_engine (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.tick_i   (s.tick),
		.start_i  (start),
		.abort_i  (wr_scr),
		.sample_i (sample),
		.busy_o   (),
		.done_o   (eng_done),
		.result_o (eng_code)
	);

	always_comb begin
		n = s;
		n.ack      = req;
		n.ain_meta = ain_i;
		n.ain_sync = s.ain_meta;
		n.pin_meta = pin_in_i;
		n.pin_sync = s.pin_meta;
		n.ain_prev = s.ain_sync;
		// taken once two reads agree: a torn word never reaches the engine
		// limitation: a level that never settles leaves the last settled one
		for (int i = 0; i < `SAC_NUM_CH; i++) begin
			if (s.ain_sync[i] == s.ain_prev[i]) begin
				n.ain_hold[i] = s.ain_sync[i];
			end
		end

		// converter clock as a one-cycle enable
		n.tick = 1'b0;
		if (s.div_cnt >= ratio_m1(s.prescale)) begin
			n.div_cnt = '0;
			n.tick    = 1'b1;
		end else begin
			n.div_cnt = s.div_cnt + `SAC_DIVCNT_W'(1);
		end

		if (start) begin
			n.seq = sac_pkg::SEQ_CONV;
		end

		// reads and clears come before the hardware sets so a set is never lost
		if (req) begin
			n.rdata = '0;
			if (hit(wb_adr_i, `SAC_ADDR_SCR)) begin
				n.rdata = {s.conversion_done_flag, s.conv_irq_enable,
				           s.continuous_mode_bit, s.channel_select_field};
			end else if (hit(wb_adr_i, `SAC_ADDR_RESULT)) begin
				n.rdata = s.result;
			end else if (hit(wb_adr_i, `SAC_ADDR_CLKDIV)) begin
				n.rdata = {s.prescale, `SAC_DIV_PAD};
			end else if (hit(wb_adr_i, `SAC_ADDR_IRQ_STAT)) begin
				n.rdata = `SAC_RES_W'(s.irq_stat);
			end else if (hit(wb_adr_i, `SAC_ADDR_IRQ_MASK)) begin
				n.rdata = `SAC_RES_W'(s.irq_mask);
			end
		end
		if (rd && hit(wb_adr_i, `SAC_ADDR_RESULT)) begin
			n.conversion_done_flag = 1'b0;
		end
		if (wr) begin
			if (hit(wb_adr_i, `SAC_ADDR_CLKDIV)) begin
				n.prescale = wb_dat_i[`SAC_DIV_HI:`SAC_DIV_LO];
				n.div_cnt  = '0;
			end
			if (hit(wb_adr_i, `SAC_ADDR_IRQ_STAT)) begin
				n.irq_stat = s.irq_stat & ~wb_dat_i[`SAC_IRQ_W-1:0];
			end
			if (hit(wb_adr_i, `SAC_ADDR_IRQ_MASK)) begin
				n.irq_mask = wb_dat_i[`SAC_IRQ_W-1:0];
			end
		end

		// a finished conversion always lands, even beside a control write
		if (eng_done && s.seq == sac_pkg::SEQ_CONV) begin
			n.result = eng_code;
			if (s.conv_irq_enable) begin
				n.irq_stat[`SAC_IRQ_DONE] = 1'b1;
			end else begin
				n.conversion_done_flag = 1'b1;
			end
			if (s.continuous_mode_bit) begin
				n.seq = sac_pkg::SEQ_ARM;
			end else begin
				n.seq = sac_pkg::SEQ_IDLE;
			end
		end

		if (wr_scr) begin
			n.conv_irq_enable      = wb_dat_i[`SAC_SCR_IRQ_EN];
			n.continuous_mode_bit  = wb_dat_i[`SAC_SCR_CONT];
			n.channel_select_field = wb_dat_i[`SAC_CHAN_W-1:0];
			if (s.seq != sac_pkg::SEQ_IDLE && !(eng_done && !s.continuous_mode_bit)) begin
				// flags the lost conversion so software can drop it
				n.irq_stat[`SAC_IRQ_ABORT] = 1'b1;
			end
			if (wb_dat_i[`SAC_CHAN_W-1:0] == `SAC_CHAN_OFF) begin
				n.seq = sac_pkg::SEQ_IDLE;
			end else begin
				n.seq = sac_pkg::SEQ_ARM;
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s          <= '0;
			s.channel_select_field <= `SAC_CHAN_OFF;
			s.irq_mask <= `SAC_MASK_RST;
		end else begin
			s <= n;
		end
	end

	for (genvar i = 0; i < `SAC_NUM_CH; i++) begin : g_pin
		assign in_use[i]      = s.channel_select_field == `SAC_CHAN_W'(i);
		assign pin_oe_o[i]    = port_ddr_i[i] & ~in_use[i];
		assign pin_out_o[i]   = port_latch_i[i];
		assign port_read_o[i] = port_ddr_i[i] ? port_latch_i[i] :
		                        (in_use[i] ? 1'b0 : s.pin_sync[i]);
	end

	assign wb_ack_o     = s.ack;
	assign wb_dat_o     = `SAC_BUS_W'(s.rdata);
	assign power_down_o = off;
	assign irq_o        = |(s.irq_stat & s.irq_mask);
	// the converter ignores wait mode, so its request can end it
	assign wake_o       = wait_mode_i & irq_o;

endmodule

// file: verif/sac_ain_model.sv
module sac_ain_model (
	input  wire logic            clk_i,
	input  wire logic [3:0][9:0] lvl_i,
	input  wire logic [3:0]      pin_out_i,
	input  wire logic [3:0]      pin_oe_i,
	output logic      [3:0][9:0] ain_o,
	output logic      [3:0]      pin_in_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// levels only move at edges the bench picks
	always_ff @(posedge clk_i) ain_o <= lvl_i;
	// an undriven pin floats high through its pull-up, never holds a stale level
	assign pin_in_o = pin_out_i | ~pin_oe_i;
endmodule

// file: verif/sac_adc_ctrl_asserts.sv
`include "sac_regs.svh"
module sac_adc_ctrl_asserts #(
	parameter int CONV_TICKS = `SAC_CONV_TICKS
) (
	input wire logic                   clk_i,
	input wire logic                   resetn_i,
	input wire logic                   wb_cyc_i,
	input wire logic                   wb_stb_i,
	input wire logic [`SAC_BUS_W-1:0]  wb_dat_o,
	input wire logic                   wb_ack_o,
	input wire logic [`SAC_NUM_CH-1:0] pin_out_o,
	input wire logic [`SAC_NUM_CH-1:0] pin_oe_o,
	input wire logic [`SAC_NUM_CH-1:0] port_latch_i,
	input wire logic [`SAC_NUM_CH-1:0] port_ddr_i,
	input wire logic [`SAC_NUM_CH-1:0] port_read_o,
	input wire logic                   wait_mode_i,
	input wire logic                   power_down_o,
	input wire logic                   irq_o,
	input wire logic                   wake_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request got no ack");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
		else $error("ack without request");
	chk_data_width: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("read data wider than 8 bits");
	chk_pd_write: assert property ($changed(power_down_o) |-> wb_ack_o)
		else $error("power down moved without a write");
	chk_wake_irq: assert property (wake_o == (wait_mode_i && irq_o))
		else $error("wake does not follow irq in wait");
	chk_pin_latch: assert property (pin_out_o == port_latch_i)
		else $error("pin output not the latch");
	chk_oe_ddr: assert property ((pin_oe_o & ~port_ddr_i) == 4'h0)
		else $error("pin driven with direction input");
	chk_oe_idle: assert property (power_down_o |-> pin_oe_o == port_ddr_i)
		else $error("pin held while powered down");
	chk_read_latch: assert property ((port_read_o & port_ddr_i) == (port_latch_i & port_ddr_i))
		else $error("output pin read not latch");
	cover property ($rose(irq_o));
	cover property (wake_o);
	cover property ($fell(power_down_o));
endmodule
bind sac_adc_ctrl sac_adc_ctrl_asserts #(.CONV_TICKS(CONV_TICKS)) u_sac_adc_ctrl_asserts (
	.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
	.port_latch_i(port_latch_i), .port_ddr_i(port_ddr_i), .port_read_o(port_read_o),
	.wait_mode_i(wait_mode_i), .power_down_o(power_down_o), .irq_o(irq_o), .wake_o(wake_o));

// file: verif/tb_top.sv
`include "sac_regs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic            clk_i = 1'b0;
	logic            resetn_i = 1'b0;
	logic            cyc = 1'b0;
	logic            we = 1'b0;
	logic            wait_mode = 1'b0;
	logic [7:0]      adr = 8'h00;
	logic [31:0]     wdat = 32'h0;
	logic [31:0]     rdat, rd;
	logic            ack, pd, irq, wake;
	logic [3:0]      pin_in, pin_out, pin_oe, prd;
	logic [3:0]      latch = 4'h0;
	logic [3:0]      ddr = 4'h0;
	logic [3:0]      sel = 4'hF;
	logic [3:0][9:0] lvl = {10'h0A5, 10'h3F0, 10'h13C, 10'h07F};
	logic [3:0][9:0] ain;
	logic [3:0][7:0] code = {8'hA5, 8'h00, 8'hFF, 8'h7F};
	int              n_errors = 0;
	int              cmp_count = 0;
	always #5 clk_i = ~clk_i;
	sac_adc_ctrl u_sac_adc_ctrl (
		.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.ain_i(ain), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
		.port_latch_i(latch), .port_ddr_i(ddr), .port_read_o(prd), .wait_mode_i(wait_mode),
		.power_down_o(pd), .irq_o(irq), .wake_o(wake));
	sac_ain_model u_sac_ain_model (.clk_i(clk_i), .lvl_i(lvl), .pin_out_i(pin_out),
		.pin_oe_i(pin_oe), .ain_o(ain), .pin_in_o(pin_in));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 50);
		rd = rdat;
		cyc <= 1'b0;
		if (k >= 50) begin
			n_errors++;
			$display("[FAIL] %0t bus ack missing", $time);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 8'h00);
		chk(rd, exp);
	endtask
	task automatic t_reset();
		rdc(`SAC_ADDR_SCR, 32'h1F);
		wb(1'b1, `SAC_ADDR_RESULT, 8'h55);
		rdc(`SAC_ADDR_RESULT, 32'h00);
		rdc(`SAC_ADDR_CLKDIV, 32'h00);
		// a write without its low byte lane must leave the register alone
		sel <= 4'hE;
		wb(1'b1, `SAC_ADDR_CLKDIV, 8'hE0);
		sel <= 4'hF;
		rdc(`SAC_ADDR_CLKDIV, 32'h00);
		rdc(`SAC_ADDR_IRQ_STAT, 32'h00);
		rdc(`SAC_ADDR_IRQ_MASK, 32'h03);
		wb(1'b1, 8'h50, 8'hFF);
		rdc(8'h50, 32'h00);
		chk(pd, 32'h1);
		$display("test reset done");
	endtask
	task automatic t_prescale();
		int n, d;
		for (int c = 0; c < 8; c++) begin
			d = (c > 3) ? 16 : (1 << c);
			wb(1'b1, `SAC_ADDR_CLKDIV, 8'(c << 5));
			wb(1'b1, `SAC_ADDR_SCR, 8'(8'h40 + c % 4));
			n = 0;
			while (irq !== 1'b1 && n < 400) begin
				@(posedge clk_i);
				n++;
			end
			chk(n >= 16 * d && n <= 18 * d + 4, 32'h1);
			wait_mode <= 1'b1;
			@(posedge clk_i);
			chk(wake, 32'h1);
			wait_mode <= 1'b0;
			rdc(`SAC_ADDR_SCR, 32'(8'h40 + c % 4));
			rdc(`SAC_ADDR_RESULT, 32'(code[c % 4]));
			wb(1'b1, `SAC_ADDR_IRQ_STAT, 8'h01);
			chk(irq, 32'h0);
		end
		$display("test prescale done");
	endtask
	task automatic t_single();
		wb(1'b1, `SAC_ADDR_CLKDIV, 8'h00);
		wb(1'b1, `SAC_ADDR_SCR, 8'h00);
		repeat (30) @(posedge clk_i);
		rdc(`SAC_ADDR_SCR, 32'h80);
		rdc(`SAC_ADDR_RESULT, 32'h7F);
		rdc(`SAC_ADDR_SCR, 32'h00);
		repeat (40) @(posedge clk_i);
		rdc(`SAC_ADDR_SCR, 32'h00);
		$display("test single done");
	endtask
	task automatic t_cont();
		wb(1'b1, `SAC_ADDR_SCR, 8'h23);
		repeat (30) @(posedge clk_i);
		lvl[3] <= 10'h033;
		repeat (60) @(posedge clk_i);
		rdc(`SAC_ADDR_RESULT, 32'h33);
		repeat (30) @(posedge clk_i);
		rdc(`SAC_ADDR_SCR, 32'hA3);
		wb(1'b1, `SAC_ADDR_SCR, 8'h1F); // cut conversion is dropped unread
		chk(pd, 32'h1);
		rdc(`SAC_ADDR_IRQ_STAT, 32'h02);
		chk(irq, 32'h1);
		wb(1'b1, `SAC_ADDR_IRQ_MASK, 8'h00);
		chk(irq, 32'h0);
		wb(1'b1, `SAC_ADDR_IRQ_MASK, 8'h03);
		lvl[3] <= 10'h0C3;
		repeat (60) @(posedge clk_i);
		rdc(`SAC_ADDR_SCR, 32'h9F);
		rdc(`SAC_ADDR_RESULT, 32'h33);
		wb(1'b1, `SAC_ADDR_IRQ_STAT, 8'h03);
		chk(irq, 32'h0);
		$display("test continuous done");
	endtask
	task automatic t_pins();
		latch <= 4'hA;
		ddr <= 4'hF;
		wb(1'b1, `SAC_ADDR_SCR, 8'h02);
		chk(pin_oe, 32'hB);
		chk(pin_out, 32'hA);
		chk(prd, 32'hA);
		ddr <= 4'h0;
		repeat (4) @(posedge clk_i);
		chk(prd, 32'hB);
		ddr <= 4'hF;
		wb(1'b1, `SAC_ADDR_SCR, 8'h1F);
		chk(pin_oe, 32'hF);
		$display("test pins done");
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_reset();
		t_prescale();
		t_single();
		t_cont();
		t_pins();
		conclude();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		conclude();
	end
endmodule
